// ===== core/sifd_cfg.svh
`ifndef SIFD_CFG_SVH
`define SIFD_CFG_SVH

// Register byte offsets on the AXI4-Lite bus
`define SIFD_OFF_CTRL      16'h0000
`define SIFD_OFF_STATUS    16'h0004
`define SIFD_OFF_CLRMASK   16'h0008
`define SIFD_OFF_FUNC0     16'h0010
`define SIFD_OFF_ZTHR      16'h0020
`define SIFD_OFF_SOFF      16'h0024
`define SIFD_OFF_GRATE     16'h0028
`define SIFD_OFF_IRQ_STS   16'h0030
`define SIFD_OFF_IRQ_CLR   16'h0034
`define SIFD_OFF_IRQ_EN    16'h0038
`define SIFD_OFF_UVTHR     16'h0430

// Control register field positions
`define SIFD_CTRL_MODE_LSB 0
`define SIFD_CTRL_GSEL_LSB 4
`define SIFD_CTRL_PCM_LSB  8
`define SIFD_CTRL_TSRC_BIT 12

// Reset values
`define SIFD_RST_UVTHR     16'h00a0
`define SIFD_RST_CLRMASK   8'h01
`define SIFD_RST_ZTHR      16'h000a
`define SIFD_RST_GRATE     16'h0100

// Undervoltage threshold range in volts rms
`define SIFD_UV_MIN        16'h008c
`define SIFD_UV_MAX        16'h00be

// Square root of two in Q14
`define SIFD_SQRT2_Q14     32'h00005a82
`define SIFD_SQRT2_FRAC    14

// Input function codes
`define SIFD_FN_ENABLE     8'h01
`define SIFD_FN_FCLR       8'h02
`define SIFD_FN_GAIN       8'h03
`define SIFD_FN_PCLR       8'h04
`define SIFD_FN_ZLOCK      8'h05
`define SIFD_FN_INV        8'h06
`define SIFD_FN_TRQ        8'h09

// Field values
`define SIFD_GSEL_DI       2'h1
`define SIFD_PCM_LEVEL     2'h0
`define SIFD_RESP_OKAY     2'h0
`define SIFD_RESP_SLVERR   2'h2

`endif

// ===== core/sifd_pkg.sv
package sifd_pkg;

	// Control mode selected by software
	typedef enum logic [1:0] {
		SIFD_POS,
		SIFD_SPD,
		SIFD_TRQ
	} sifd_mode_t;

	// One bit per fault source, bit 0 is undervoltage
	typedef logic [7:0]  sifd_fault_t;

	// Input function code of one input line
	typedef logic [7:0]  sifd_code_t;

	// Sticky event bits for the interrupt
	typedef logic [2:0]  sifd_irq_t;

endpackage

// ===== core/sifd_if.sv
`timescale 1ns/1ps

// Synchronised input levels and rising edges
interface sifd_if #(parameter int N = 8);
	logic [N-1:0] lvl;   // Level after two flip-flops
	logic [N-1:0] rise;  // One-cycle pulse on a rising level

	modport src (output lvl, output rise);
	modport snk (input lvl, input rise);
endinterface

// ===== core/sifd_di_sync.sv
`timescale 1ns/1ps

module sifd_di_sync #(
	parameter int N = 8
) (
	input  wire logic          aclk,
	input  wire logic          aresetn,
	input  wire logic [N-1:0]  pins,
	sifd_if.src                port
);
	import sifd_pkg::*;

	logic [N-1:0] s1_r;    // First synchroniser stage
	logic [N-1:0] s2_r;    // Second synchroniser stage
	logic [N-1:0] s3_r;    // Delayed level for edge detection
	logic [N-1:0] s1_nxt;
	logic [N-1:0] s2_nxt;
	logic [N-1:0] s3_nxt;

	// Next values of the three stages, one per line
	for (genvar g = 0; g < N; g++) begin : g_line
		always_comb begin
			s1_nxt[g] = pins[g];
			s2_nxt[g] = s1_r[g];
			s3_nxt[g] = s2_r[g];
		end
	end

	// Stage registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
		end else begin
			s1_r <= s1_nxt;
			s2_r <= s2_nxt;
			s3_r <= s3_nxt;
		end
	end

	// Only the second and third stages are looked at
	assign port.lvl  = s2_r;
	assign port.rise = s2_r & ~s3_r;

endmodule // sifd_di_sync

// ===== core/sifd_top.sv
// Contract
// - Undervoltage fault when bus below threshold times root two
// - Add speed offset to analog speed in speed mode
// - Enable input level enables drive, all modes
// - Fault clear rising edge clears clearable faults only
// - Gain boost level with selection one multiplies gain in speed, position
// - Pulse clear in position mode, mode zero continuous
// - Zero-speed lock holds position below speed threshold in speed mode
// - Command invert level reverses rotation direction
// - Torque limit level applies limit in speed, position
`timescale 1ns/1ps
`include "sifd_cfg.svh"

module sifd_top #(
	parameter int NDI = 8
) (
	input  wire logic               aclk,
	input  wire logic               aresetn,
	input  wire logic [15:0]        s_axi_awaddr,
	input  wire logic               s_axi_awvalid,
	output wire logic               s_axi_awready,
	input  wire logic [31:0]        s_axi_wdata,
	input  wire logic [3:0]         s_axi_wstrb,
	input  wire logic               s_axi_wvalid,
	output wire logic               s_axi_wready,
	output wire logic [1:0]         s_axi_bresp,
	output wire logic               s_axi_bvalid,
	input  wire logic               s_axi_bready,
	input  wire logic [15:0]        s_axi_araddr,
	input  wire logic               s_axi_arvalid,
	output wire logic               s_axi_arready,
	output wire logic [31:0]        s_axi_rdata,
	output wire logic [1:0]         s_axi_rresp,
	output wire logic               s_axi_rvalid,
	input  wire logic               s_axi_rready,
	input  wire logic [NDI-1:0]     di_pin,
	input  wire logic [15:0]        dc_bus_voltage,
	input  wire logic [15:0]        motor_speed,
	input  wire logic signed [15:0] analog_speed_in,
	input  wire logic [15:0]        loop_gain_base,
	input  wire sifd_pkg::sifd_fault_t fault_raise,
	output wire logic               drive_enable,
	output wire logic               gain_boost_active,
	output wire logic [15:0]        loop_gain_out,
	output wire logic               pulse_count_clear,
	output wire logic               zero_speed_hold,
	output wire logic               command_invert,
	output wire logic               torque_limit_enable,
	output wire logic               torque_limit_from_analog,
	output wire logic signed [15:0] speed_command,
	output wire sifd_pkg::sifd_fault_t fault_active,
	output wire logic               irq
);
	import sifd_pkg::*;

	localparam int NW   = (NDI + 3) / 4;  // Function code words
	localparam int IRQL = 1;              // Torque limit latency bound in checks

	// Synchronised input lines
	sifd_if #(.N(NDI)) di_bus ();

	sifd_di_sync #(.N(NDI)) u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.pins    (di_pin),
		.port    (di_bus.src)
	);

	// Software registers
	sifd_mode_t  mode_r,    mode_nxt;     // Control mode
	logic [1:0]  gsel_r,    gsel_nxt;     // Gain switch selection
	logic [1:0]  pcm_r,     pcm_nxt;      // Pulse clear mode
	logic        tsrc_r,    tsrc_nxt;     // Torque limit from analog
	sifd_fault_t clrmask_r, clrmask_nxt;  // Clearable fault classes
	sifd_code_t  func_r   [NDI];          // Function code per line
	sifd_code_t  func_nxt [NDI];
	logic [15:0] zthr_r,    zthr_nxt;     // Zero-speed threshold
	logic [15:0] soff_r,    soff_nxt;     // Analog speed offset
	logic [15:0] grate_r,   grate_nxt;    // Gain rate, Q8.8
	logic [15:0] uvthr_r,   uvthr_nxt;    // Undervoltage threshold
	sifd_irq_t   irq_en_r,  irq_en_nxt;   // Interrupt enable
	sifd_irq_t   irq_sts_r, irq_sts_nxt;  // Sticky event bits

	// Bus handshake state
	logic        bvalid_r,  bvalid_nxt;
	logic [1:0]  bresp_r,   bresp_nxt;
	logic        rvalid_r,  rvalid_nxt;
	logic [1:0]  rresp_r,   rresp_nxt;
	logic [31:0] rdata_r,   rdata_nxt;

	// Drive side outputs
	logic        en_r,   en_nxt;
	logic        gain_r, gain_nxt;
	logic [15:0] lgo_r,  lgo_nxt;
	logic        pcc_r,  pcc_nxt;
	logic        zh_r,   zh_nxt;
	logic        inv_r,  inv_nxt;
	logic        trq_r,  trq_nxt;
	logic signed [15:0] spd_r, spd_nxt;
	sifd_fault_t fault_r, fault_nxt;

	// Per-line function matches
	logic [NDI-1:0] m_en, m_clr, m_gain, m_pcl, m_pce, m_zl, m_inv, m_trq;

	logic        wr_fire;     // Write address and data taken
	logic        rd_fire;     // Read address taken
	logic        uv_below;    // Bus below scaled threshold
	logic        fclr;        // Fault clear edge seen
	sifd_fault_t fault_set;   // Faults raised this cycle
	sifd_irq_t   ev;          // Interrupt events this cycle
	sifd_irq_t   irq_clr;     // Bits written to the clear register
	logic [31:0] uv_lhs;
	logic [31:0] uv_rhs;
	logic [31:0] gprod;
	logic signed [16:0] ssum;

	// Byte-lane merge of a write into an old value
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [3:0] st);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (st[b]) begin
				res[8*b +: 8] = s_axi_wdata[8*b +: 8];
			end
		end
		return res;
	endfunction

	assign wr_fire       = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
	assign rd_fire       = s_axi_arvalid && !rvalid_r;
	assign s_axi_awready = s_axi_wvalid && !bvalid_r;
	assign s_axi_wready  = s_axi_awvalid && !bvalid_r;
	assign s_axi_arready = !rvalid_r;

	// Decode of each input line by its function code
	for (genvar g = 0; g < NDI; g++) begin : g_dec
		// Codes without a match here drive nothing
		assign m_en[g]   = di_bus.lvl[g]  && (func_r[g] == `SIFD_FN_ENABLE);
		assign m_clr[g]  = di_bus.rise[g] && (func_r[g] == `SIFD_FN_FCLR);
		assign m_gain[g] = di_bus.lvl[g]  && (func_r[g] == `SIFD_FN_GAIN);
		assign m_pcl[g]  = di_bus.lvl[g]  && (func_r[g] == `SIFD_FN_PCLR);
		assign m_pce[g]  = di_bus.rise[g] && (func_r[g] == `SIFD_FN_PCLR);
		assign m_zl[g]   = di_bus.lvl[g]  && (func_r[g] == `SIFD_FN_ZLOCK);
		assign m_inv[g]  = di_bus.lvl[g]  && (func_r[g] == `SIFD_FN_INV);
		assign m_trq[g]  = di_bus.lvl[g]  && (func_r[g] == `SIFD_FN_TRQ);
	end

	// Undervoltage compare in Q14 without rounding loss
	assign uv_lhs    = {2'h0, dc_bus_voltage, 14'h0000};
	assign uv_rhs    = 32'(uvthr_r) * `SIFD_SQRT2_Q14;
	assign uv_below  = uv_lhs < uv_rhs;
	assign fclr      = |m_clr;
	assign fault_set = fault_raise | {7'h00, uv_below};
	assign ev        = {fclr, |(fault_set & ~fault_r), uv_below && !fault_r[0]};
	assign irq_clr   = (wr_fire && s_axi_awaddr == `SIFD_OFF_IRQ_CLR && s_axi_wstrb[0])
	                   ? s_axi_wdata[2:0] : 3'h0;

	// Register writes, address decode and write response
	always_comb begin
		logic [31:0] ctl;
		ctl         = merge({19'h0, tsrc_r, 2'h0, pcm_r, 2'h0, gsel_r, 2'h0, mode_r},
		                    s_axi_wstrb);
		mode_nxt    = mode_r;
		gsel_nxt    = gsel_r;
		pcm_nxt     = pcm_r;
		tsrc_nxt    = tsrc_r;
		clrmask_nxt = clrmask_r;
		zthr_nxt    = zthr_r;
		soff_nxt    = soff_r;
		grate_nxt   = grate_r;
		uvthr_nxt   = uvthr_r;
		irq_en_nxt  = irq_en_r;
		func_nxt    = func_r;
		bvalid_nxt  = bvalid_r && !s_axi_bready;
		bresp_nxt   = bresp_r;
		if (wr_fire) begin
			bvalid_nxt = 1'b1;
			bresp_nxt  = `SIFD_RESP_OKAY;
			if (s_axi_awaddr == `SIFD_OFF_CTRL) begin
				// Unknown mode code falls back to position
				if (ctl[`SIFD_CTRL_MODE_LSB +: 2] == 2'h1) begin
					mode_nxt = SIFD_SPD;
				end else if (ctl[`SIFD_CTRL_MODE_LSB +: 2] == 2'h2) begin
					mode_nxt = SIFD_TRQ;
				end else begin
					mode_nxt = SIFD_POS;
				end
				gsel_nxt = ctl[`SIFD_CTRL_GSEL_LSB +: 2];
				pcm_nxt  = ctl[`SIFD_CTRL_PCM_LSB +: 2];
				tsrc_nxt = ctl[`SIFD_CTRL_TSRC_BIT];
			end else if (s_axi_awaddr == `SIFD_OFF_CLRMASK) begin
				clrmask_nxt = 8'(merge({24'h0, clrmask_r}, s_axi_wstrb));
			end else if (s_axi_awaddr >= `SIFD_OFF_FUNC0 &&
			             s_axi_awaddr < `SIFD_OFF_FUNC0 + 16'(4 * NW) &&
			             s_axi_awaddr[1:0] == 2'h0) begin
				// Four codes per word, one per byte lane
				for (int i = 0; i < NDI; i++) begin
					if (s_axi_awaddr == `SIFD_OFF_FUNC0 + 16'(4 * (i / 4)) &&
					    s_axi_wstrb[i % 4]) begin
						func_nxt[i] = s_axi_wdata[8 * (i % 4) +: 8];
					end
				end
			end else if (s_axi_awaddr == `SIFD_OFF_ZTHR) begin
				zthr_nxt = 16'(merge({16'h0, zthr_r}, s_axi_wstrb));
			end else if (s_axi_awaddr == `SIFD_OFF_SOFF) begin
				soff_nxt = 16'(merge({16'h0, soff_r}, s_axi_wstrb));
			end else if (s_axi_awaddr == `SIFD_OFF_GRATE) begin
				grate_nxt = 16'(merge({16'h0, grate_r}, s_axi_wstrb));
			end else if (s_axi_awaddr == `SIFD_OFF_IRQ_CLR) begin
				bresp_nxt = `SIFD_RESP_OKAY;
			end else if (s_axi_awaddr == `SIFD_OFF_IRQ_EN) begin
				irq_en_nxt = 3'(merge({29'h0, irq_en_r}, s_axi_wstrb));
			end else if (s_axi_awaddr == `SIFD_OFF_UVTHR) begin
				// Values outside the allowed range are dropped
				if (16'(merge({16'h0, uvthr_r}, s_axi_wstrb)) >= `SIFD_UV_MIN &&
				    16'(merge({16'h0, uvthr_r}, s_axi_wstrb)) <= `SIFD_UV_MAX) begin
					uvthr_nxt = 16'(merge({16'h0, uvthr_r}, s_axi_wstrb));
				end
			end else if (s_axi_awaddr == `SIFD_OFF_STATUS ||
			             s_axi_awaddr == `SIFD_OFF_IRQ_STS) begin
				bresp_nxt = `SIFD_RESP_OKAY;
			end else begin
				bresp_nxt = `SIFD_RESP_SLVERR;
			end
		end
	end

	// Read data mux and read response
	always_comb begin
		rvalid_nxt = rvalid_r && !s_axi_rready;
		rresp_nxt  = rresp_r;
		rdata_nxt  = rdata_r;
		if (rd_fire) begin
			rvalid_nxt = 1'b1;
			rresp_nxt  = `SIFD_RESP_OKAY;
			rdata_nxt  = 32'h0;
			if (s_axi_araddr == `SIFD_OFF_CTRL) begin
				rdata_nxt = {19'h0, tsrc_r, 2'h0, pcm_r, 2'h0, gsel_r, 2'h0, mode_r};
			end else if (s_axi_araddr == `SIFD_OFF_STATUS) begin
				rdata_nxt = {16'h0, fault_r, 2'h0, trq_r, inv_r, zh_r, pcc_r, gain_r, en_r};
			end else if (s_axi_araddr == `SIFD_OFF_CLRMASK) begin
				rdata_nxt = {24'h0, clrmask_r};
			end else if (s_axi_araddr >= `SIFD_OFF_FUNC0 &&
			             s_axi_araddr < `SIFD_OFF_FUNC0 + 16'(4 * NW) &&
			             s_axi_araddr[1:0] == 2'h0) begin
				for (int i = 0; i < NDI; i++) begin
					if (s_axi_araddr == `SIFD_OFF_FUNC0 + 16'(4 * (i / 4))) begin
						rdata_nxt[8 * (i % 4) +: 8] = func_r[i];
					end
				end
			end else if (s_axi_araddr == `SIFD_OFF_ZTHR) begin
				rdata_nxt = {16'h0, zthr_r};
			end else if (s_axi_araddr == `SIFD_OFF_SOFF) begin
				rdata_nxt = {16'h0, soff_r};
			end else if (s_axi_araddr == `SIFD_OFF_GRATE) begin
				rdata_nxt = {16'h0, grate_r};
			end else if (s_axi_araddr == `SIFD_OFF_IRQ_STS) begin
				rdata_nxt = {29'h0, irq_sts_r};
			end else if (s_axi_araddr == `SIFD_OFF_IRQ_EN) begin
				rdata_nxt = {29'h0, irq_en_r};
			end else if (s_axi_araddr == `SIFD_OFF_UVTHR) begin
				rdata_nxt = {16'h0, uvthr_r};
			end else if (s_axi_araddr == `SIFD_OFF_IRQ_CLR) begin
				rdata_nxt = 32'h0;
			end else begin
				rresp_nxt = `SIFD_RESP_SLVERR;
			end
		end
	end

	// Drive actions, faults and sticky events
	always_comb begin
		en_nxt      = |m_en;
		gain_nxt    = (|m_gain) && gsel_r == `SIFD_GSEL_DI && mode_r != SIFD_TRQ;
		gprod       = 32'(loop_gain_base) * 32'(grate_r);
		lgo_nxt     = loop_gain_base;
		if (gain_nxt) begin
			lgo_nxt = (gprod[31:24] != 8'h00) ? 16'hffff : gprod[23:8];
		end
		// Mode zero clears while held, other modes on the edge only
		pcc_nxt     = mode_r == SIFD_POS &&
		              ((pcm_r == `SIFD_PCM_LEVEL) ? (|m_pcl) : (|m_pce));
		zh_nxt      = (|m_zl) && mode_r == SIFD_SPD && motor_speed < zthr_r;
		inv_nxt     = |m_inv;
		trq_nxt     = (|m_trq) && mode_r != SIFD_TRQ;
		ssum        = 17'(analog_speed_in) + 17'($signed(soff_r));
		spd_nxt     = analog_speed_in;
		if (mode_r == SIFD_SPD) begin
			// Saturate instead of wrapping the direction
			if (ssum > 17'sh07fff) begin
				spd_nxt = 16'sh7fff;
			end else if (ssum < -17'sh08000) begin
				spd_nxt = -16'sh8000;
			end else begin
				spd_nxt = ssum[15:0];
			end
		end
		// Raise wins over clear in the same cycle
		fault_nxt   = (fault_r & ~(fclr ? clrmask_r : 8'h00)) | fault_set;
		irq_sts_nxt = (irq_sts_r & ~irq_clr) | ev;
	end

	// All state registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_r    <= SIFD_POS;
			gsel_r    <= 2'h0;
			pcm_r     <= 2'h0;
			tsrc_r    <= 1'b0;
			clrmask_r <= `SIFD_RST_CLRMASK;
			func_r    <= '{default: 8'h00};
			zthr_r    <= `SIFD_RST_ZTHR;
			soff_r    <= 16'h0000;
			grate_r   <= `SIFD_RST_GRATE;
			uvthr_r   <= `SIFD_RST_UVTHR;
			irq_en_r  <= 3'h0;
			irq_sts_r <= 3'h0;
			bvalid_r  <= 1'b0;
			bresp_r   <= 2'h0;
			rvalid_r  <= 1'b0;
			rresp_r   <= 2'h0;
			rdata_r   <= 32'h0;
			en_r      <= 1'b0;
			gain_r    <= 1'b0;
			lgo_r     <= 16'h0000;
			pcc_r     <= 1'b0;
			zh_r      <= 1'b0;
			inv_r     <= 1'b0;
			trq_r     <= 1'b0;
			spd_r     <= 16'sh0000;
			fault_r   <= 8'h00;
		end else begin
			mode_r    <= mode_nxt;
			gsel_r    <= gsel_nxt;
			pcm_r     <= pcm_nxt;
			tsrc_r    <= tsrc_nxt;
			clrmask_r <= clrmask_nxt;
			func_r    <= func_nxt;
			zthr_r    <= zthr_nxt;
			soff_r    <= soff_nxt;
			grate_r   <= grate_nxt;
			uvthr_r   <= uvthr_nxt;
			irq_en_r  <= irq_en_nxt;
			irq_sts_r <= irq_sts_nxt;
			bvalid_r  <= bvalid_nxt;
			bresp_r   <= bresp_nxt;
			rvalid_r  <= rvalid_nxt;
			rresp_r   <= rresp_nxt;
			rdata_r   <= rdata_nxt;
			en_r      <= en_nxt;
			gain_r    <= gain_nxt;
			lgo_r     <= lgo_nxt;
			pcc_r     <= pcc_nxt;
			zh_r      <= zh_nxt;
			inv_r     <= inv_nxt;
			trq_r     <= trq_nxt;
			spd_r     <= spd_nxt;
			fault_r   <= fault_nxt;
		end
	end

	assign s_axi_bvalid             = bvalid_r;
	assign s_axi_bresp              = bresp_r;
	assign s_axi_rvalid             = rvalid_r;
	assign s_axi_rresp              = rresp_r;
	assign s_axi_rdata              = rdata_r;
	assign drive_enable             = en_r;
	assign gain_boost_active        = gain_r;
	assign loop_gain_out            = lgo_r;
	assign pulse_count_clear        = pcc_r;
	assign zero_speed_hold          = zh_r;
	assign command_invert           = inv_r;
	assign torque_limit_enable      = trq_r;
	assign torque_limit_from_analog = trq_r && tsrc_r;
	assign speed_command            = spd_r;
	assign fault_active             = fault_r;
	assign irq                      = |(irq_sts_r & irq_en_r);

	// Checks on the drive side behaviour
	sequence s_uv_low;
		uv_below;
	endsequence
	sequence s_clr_ok;
		fclr && clrmask_r[0] && !fault_set[0];
	endsequence

	property p_uv;
		@(posedge aclk) disable iff (!aresetn) s_uv_low |=> fault_r[0];
	endproperty
	a_uv: assert property (p_uv) else $error("undervoltage not raised");

	property p_spd;
		@(posedge aclk) disable iff (!aresetn)
		(mode_r == SIFD_SPD && soff_r == 16'h0000) |=> speed_command == $past(analog_speed_in);
	endproperty
	a_spd: assert property (p_spd) else $error("speed offset path wrong");

	property p_en;
		@(posedge aclk) disable iff (!aresetn) (|m_en) |=> drive_enable;
	endproperty
	a_en: assert property (p_en) else $error("drive not enabled");

	property p_clr;
		@(posedge aclk) disable iff (!aresetn) s_clr_ok |=> !fault_r[0];
	endproperty
	a_clr: assert property (p_clr) else $error("clearable fault kept");

	property p_keep;
		@(posedge aclk) disable iff (!aresetn) (fault_r[1] && !clrmask_r[1]) |=> fault_r[1];
	endproperty
	a_keep: assert property (p_keep) else $error("unclearable fault lost");

	property p_gain;
		@(posedge aclk) disable iff (!aresetn)
		gain_boost_active |-> $past(gsel_r) == `SIFD_GSEL_DI && $past(|m_gain);
	endproperty
	a_gain: assert property (p_gain) else $error("gain boost without cause");

	property p_pcc;
		@(posedge aclk) disable iff (!aresetn)
		(mode_r == SIFD_POS && pcm_r == `SIFD_PCM_LEVEL && (|m_pcl))[*2] |=> pulse_count_clear;
	endproperty
	a_pcc: assert property (p_pcc) else $error("pulse count not cleared");

	property p_zl;
		@(posedge aclk) disable iff (!aresetn)
		zero_speed_hold |-> $past(mode_r) == SIFD_SPD && $past(motor_speed) < $past(zthr_r);
	endproperty
	a_zl: assert property (p_zl) else $error("lock outside speed limit");

	property p_inv;
		@(posedge aclk) disable iff (!aresetn) (|m_inv) |=> command_invert;
	endproperty
	a_inv: assert property (p_inv) else $error("invert not applied");

	property p_trq;
		@(posedge aclk) disable iff (!aresetn)
		((|m_trq) && mode_r != SIFD_TRQ) |=> ##[0:IRQL] torque_limit_enable;
	endproperty
	a_trq: assert property (p_trq) else $error("torque limit not applied");

endmodule // sifd_top

// ===== verif/sifd_host.sv
`timescale 1ns/1ps

// Host controller model: drives the input lines as plain held levels
module sifd_host (
	input  wire logic       aclk,
	input  wire logic [7:0] want,
	output logic      [7:0] di_pin
);
	// Each level is held until the host changes it; clear edges are fresh lows to highs
	always_ff @(posedge aclk) begin
		di_pin <= want;
	end
endmodule // sifd_host

// ===== verif/sifd_top_tb.sv
`timescale 1ns/1ps
`include "sifd_cfg.svh"

module sifd_top_tb;
	import sifd_pkg::*;
	logic              aclk, aresetn, awv, wv, brdy, arv, rrdy;  // Clock, reset, requests
	logic              awr, wrdy, bv, arr, rv, irq;             // Slave answers, interrupt
	logic [15:0]       awa, ara, dcv, spd, gbase, gout;         // Addresses and data paths
	logic [31:0]       wd, rdat, v;                             // Bus data, last read
	logic [1:0]        bresp, rresp, r;                         // Responses
	logic [7:0]        want, pins;                              // Host wish, line levels
	logic signed [15:0] asp, scmd;                              // Speed in and out
	sifd_fault_t       fr, fa;                                  // Fault raise and active
	logic              en, gba, pcc, zh, ci, tle, tla;          // Drive outputs
	int                bad_count, checks_done, cyc;             // Counters

	sifd_top #(.NDI(8)) dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
		.s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(brdy),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rrdy),
		.di_pin(pins), .dc_bus_voltage(dcv), .motor_speed(spd), .analog_speed_in(asp),
		.loop_gain_base(gbase), .fault_raise(fr), .drive_enable(en),
		.gain_boost_active(gba), .loop_gain_out(gout), .pulse_count_clear(pcc),
		.zero_speed_hold(zh), .command_invert(ci), .torque_limit_enable(tle),
		.torque_limit_from_analog(tla), .speed_command(scmd), .fault_active(fa), .irq(irq));

	sifd_host host (.aclk(aclk), .want(want), .di_pin(pins));

	// Clock of 5 ns period
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end

	// Hang guard
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			final_report;
		end
	end

	task automatic chk(string n, logic [31:0] got, logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			$display("CHECK FAILED %s exp %h got %h", n, exp, got);
			bad_count++;
		end
	endtask

	// Write: both channels offered together, each released when taken
	task automatic wr(logic [15:0] a, logic [31:0] d);
		bit pa, pw;
		@(posedge aclk);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		brdy <= 1'b1;
		pa = 1;
		pw = 1;
		while (pa || pw) begin
			@(posedge aclk);
			if (pa && awr) begin
				pa = 0;
				awv <= 1'b0;
			end
			if (pw && wrdy) begin
				pw = 0;
				wv <= 1'b0;
			end
		end
		do @(posedge aclk); while (!bv);
		r = bresp;
		brdy <= 1'b0;
	endtask

	// Read: data and response taken at the rvalid edge
	task automatic rd(logic [15:0] a);
		@(posedge aclk);
		ara <= a;
		arv <= 1'b1;
		rrdy <= 1'b1;
		do @(posedge aclk); while (!arr);
		arv <= 1'b0;
		do @(posedge aclk); while (!rv);
		v = rdat;
		r = rresp;
		rrdy <= 1'b0;
	endtask

	// Host sets the lines, then outputs settle past the sync chain
	task automatic drive(logic [7:0] p);
		want <= p;
		repeat (6) @(posedge aclk);
	endtask

	task automatic t_regs;
		rd(`SIFD_OFF_UVTHR);
		chk("uv_rst", v, 32'h00a0);
		wr(`SIFD_OFF_UVTHR, 32'h008b);
		rd(`SIFD_OFF_UVTHR);
		chk("uv_low", v, 32'h00a0);
		wr(`SIFD_OFF_UVTHR, 32'h00bf);
		rd(`SIFD_OFF_UVTHR);
		chk("uv_high", v, 32'h00a0);
		wr(`SIFD_OFF_UVTHR, 32'h00be);
		rd(`SIFD_OFF_UVTHR);
		chk("uv_max", v, 32'h00be);
		rd(16'h0100);
		chk("unmapped", r, 2'h2);
		wr(16'h0100, 32'h0);
		chk("unmapped_wr", r, 2'h2);
		wr(`SIFD_OFF_UVTHR, 32'h00a0);
	endtask

	// Bus limit at 160 lies between 226 and 227; interrupt masked, raised, cleared
	task automatic t_uv;
		dcv <= 16'd227;
		repeat (3) @(posedge aclk);
		chk("uv_above", fa, 8'h00);
		dcv <= 16'd226;
		repeat (3) @(posedge aclk);
		chk("uv_below", fa, 8'h01);
		chk("irq_mask", irq, 1'b0);
		wr(`SIFD_OFF_IRQ_EN, 32'h1);
		chk("irq_on", irq, 1'b1);
		wr(`SIFD_OFF_IRQ_CLR, 32'h1);
		chk("irq_clr", irq, 1'b0);
		wr(`SIFD_OFF_FUNC0, 32'h00000200);
		dcv <= 16'd400;
		fr <= 8'h02;
		@(posedge aclk);
		fr <= 8'h00;
		drive(8'h02);
		drive(8'h00);
		chk("fclr", fa, 8'h02);
	endtask

	// Position mode levels
	task automatic t_lvl;
		wr(`SIFD_OFF_FUNC0, 32'h04030201);
		wr(`SIFD_OFF_FUNC0 + 16'h4, 32'h09070605);
		drive(8'h40);
		chk("reserved", {en, gba, pcc, zh, ci, tle}, 6'h0);
		drive(8'h01);
		chk("enable", en, 1'b1);
		drive(8'ha1);
		chk("invert", ci, 1'b1);
		chk("trq_lim", {tle, tla}, 2'b10);
		gbase <= 16'h0200;
		wr(`SIFD_OFF_GRATE, 32'h0200);
		drive(8'ha5);
		chk("gain_sel0", gout, 16'h0200);
		wr(`SIFD_OFF_CTRL, 32'h10);
		repeat (4) @(posedge aclk);
		chk("gain_boost", {gba, gout}, {1'b1, 16'h0400});
		drive(8'had);
		chk("pclr", pcc, 1'b1);
		repeat (5) @(posedge aclk);
		chk("pclr_hold", pcc, 1'b1);
		drive(8'h00);
		chk("off", {en, pcc}, 2'b00);
		wr(`SIFD_OFF_CTRL, 32'h110);
		want <= 8'h08;
		repeat (5) @(posedge aclk);
		chk("pclr_edge", pcc, 1'b1);
		@(posedge aclk);
		chk("pclr_once", pcc, 1'b0);
		drive(8'h00);
	endtask

	// Speed mode: offset, zero lock, gating
	task automatic t_spd;
		wr(`SIFD_OFF_CTRL, 32'h11);
		wr(`SIFD_OFF_SOFF, 32'h10);
		asp <= 16'sh0100;
		spd <= 16'd5;
		drive(8'h98);
		chk("spd_off", scmd, 16'h0110);
		chk("pclr_spd", pcc, 1'b0);
		chk("zlock", zh, 1'b1);
		chk("trq_spd", tle, 1'b1);
		spd <= 16'd20;
		repeat (3) @(posedge aclk);
		chk("zlock_fast", zh, 1'b0);
		wr(`SIFD_OFF_CTRL, 32'h1011);
		chk("trq_analog", {tle, tla}, 2'b11);
		wr(`SIFD_OFF_CTRL, 32'h12);
		repeat (3) @(posedge aclk);
		chk("trq_tmode", tle, 1'b0);
	endtask

	task automatic final_report;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Reset for two cycles, then the scenarios
	initial begin
		{aresetn, awv, wv, brdy, arv, rrdy, awa, ara, wd, want} = '0;
		{spd, gbase, asp, fr, bad_count, checks_done, cyc} = '0;
		dcv = 16'd400;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs;
		t_uv;
		t_lvl;
		t_spd;
		final_report;
	end
endmodule // sifd_top_tb
